// *** rtl/usb_gen_regs.sv ***
// general command register set behind the parallel command/data port
// assumes host pins arrive asynchronous; usb event inputs are synchronous to sys_clk
`timescale 1ns/1ns

// Operation
// - writing key AA37H through the unlock command releases write protection
// - B2 writes two scratch bytes, B3 reads them back
// - scratch bit 15 stays zero, bits 14..0 store, reset clears all
// - B4 returns frame number of the last good start-of-frame packet
// - frame number may be read as one or two bytes, low byte first
// - frame number is 11 bits, bits 15..11 read zero
// - bus reset leaves frame number unchanged; power-up value is zero
// - narrow bus: select high for command, low for data, byte 0 first
// - wide bus: command from low byte, upper lines ignored, one data word
// - B5 returns identification code high, silicon version low
// - silicon version byte is binary coded decimal
// - C0 returns four-byte interrupt source register; host reads all four
// - endpoint flags at bits 23..8, bits 31..24 read zero
// - low byte carries bus state, pseudo frame, frame, end, suspend, resume, reset
// - bus state bit shows the bus condition at the time the C0 command is written
// - per-source enable gates logged flags onto the request output
// - unlock key sent with command B0, two bytes, low first
// - while suspended writes are refused; reads need the unlock first
// - interrupt read clears event flags; endpoint flags clear on status read
module usb_gen_regs #(
  parameter logic [7:0] IDENT_CODE      = 8'h5A, // arbitrary value
  parameter logic [7:0] SILICON_VERSION = 8'h10  // arbitrary value, bcd
) (
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  input  wire usb_gen_regs_pkg::hostPins_t  hostPins,
  input  wire usb_gen_regs_pkg::usbEvents_t usbEvents,
  input  wire logic [23:0]               intEnable,
  output logic [15:0]                    hostDataOut,
  output logic                           hostDataOe,
  output logic                           intRequest,
  output logic                           writeLocked
);

  usb_gen_regs_pkg::state_t s;
  usb_gen_regs_pkg::state_t next_s;

  logic        rdWas;
  logic        rdNow;
  logic        wrWas;
  logic        wrNow;
  logic        wide;
  logic        selCmd;
  logic [15:0] pinData;
  logic [15:0] word;
  logic [31:0] readValue;
  logic [15:0] readWord;
  logic        lastRead;
  logic [23:0] clearMask;
  logic [23:0] setMask;

  always_comb begin
    next_s = s;
    readValue = 32'h00000000;
    readWord  = 16'h0000;
    word      = 16'h0000;
    lastRead  = 1'b0;
    clearMask = 24'h000000;
    setMask   = 24'h000000;

    // three-stage pin synchroniser, a change counts once stages two and three agree
    next_s.sync1 = hostPins;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    for (int i = 0; i < usb_gen_regs_pkg::PIN_COUNT; i++) begin
      if (s.sync2[i] == s.sync3[i]) begin
        next_s.filt[i] = s.sync3[i];
      end
    end

    rdWas   = ~s.filt[usb_gen_regs_pkg::PIN_CS] & ~s.filt[usb_gen_regs_pkg::PIN_RD];
    rdNow   = ~next_s.filt[usb_gen_regs_pkg::PIN_CS] & ~next_s.filt[usb_gen_regs_pkg::PIN_RD];
    wrWas   = ~s.filt[usb_gen_regs_pkg::PIN_CS] & ~s.filt[usb_gen_regs_pkg::PIN_WR];
    wrNow   = ~next_s.filt[usb_gen_regs_pkg::PIN_CS] & ~next_s.filt[usb_gen_regs_pkg::PIN_WR];
    wide    = next_s.filt[usb_gen_regs_pkg::PIN_WIDE];
    selCmd  = next_s.filt[usb_gen_regs_pkg::PIN_SEL];
    pinData = next_s.filt[usb_gen_regs_pkg::PIN_DATA_LSB +: 16];

    // source of the current read, by command
    case (s.cmd)
      usb_gen_regs_pkg::CMD_SCRATCH_READ: begin
        readValue = {16'h0000, s.scratch};
      end
      usb_gen_regs_pkg::CMD_FRAME_READ: begin
        readValue = {21'h000000, s.frame};
      end
      usb_gen_regs_pkg::CMD_IDENT_READ: begin
        readValue = {16'h0000, IDENT_CODE, SILICON_VERSION};
      end
      usb_gen_regs_pkg::CMD_INT_READ: begin
        readValue = s.snap;
      end
      default: begin
        readValue = 32'h00000000;
      end
    endcase

    // least significant part first on both widths
    if (wide) begin
      readWord = s.idx[0] ? readValue[31:16] : readValue[15:0];
    end else begin
      case (s.idx)
        2'h0: readWord = {8'h00, readValue[7:0]};
        2'h1: readWord = {8'h00, readValue[15:8]};
        2'h2: readWord = {8'h00, readValue[23:16]};
        default: readWord = {8'h00, readValue[31:24]};
      endcase
    end
    if (s.locked) begin
      readWord = 16'h0000;
    end

    // read strobe: present data while active, step the byte index at its end
    next_s.dataOe = rdNow & ~selCmd;
    if (rdNow && !rdWas && !selCmd) begin
      next_s.dataOut = readWord;
    end
    if (rdWas && !rdNow && !s.filt[usb_gen_regs_pkg::PIN_SEL]) begin
      lastRead   = wide ? s.idx[0] : (s.idx == 2'h3);
      next_s.idx = s.idx + 2'h1;
      if (s.cmd == usb_gen_regs_pkg::CMD_INT_READ && lastRead && !s.locked) begin
        clearMask  = s.snap[23:0] & usb_gen_regs_pkg::CLEAR_ON_READ;
        next_s.idx = 2'h0;
      end
    end

    // write strobe: command phase or data phase
    if (wrNow && !wrWas) begin
      if (selCmd) begin
        next_s.cmd = pinData[7:0];
        next_s.idx = 2'h0;
        if (pinData[7:0] == usb_gen_regs_pkg::CMD_INT_READ) begin
          // snapshot keeps the four bytes coherent; bus state is live at this point
          next_s.snap = {8'h00, s.flags[23:8], usbEvents.busSuspended, 1'b0, s.flags[5:0]};
        end
      end else if (!wide && s.idx == 2'h0) begin
        next_s.lowHold = pinData[7:0];
        next_s.idx     = 2'h1;
      end else begin
        word       = wide ? pinData : {pinData[7:0], s.lowHold};
        next_s.idx = 2'h0;
        if (s.cmd == usb_gen_regs_pkg::CMD_UNLOCK && word == usb_gen_regs_pkg::UNLOCK_KEY) begin
          next_s.locked = 1'b0;
        end
        if (s.cmd == usb_gen_regs_pkg::CMD_SCRATCH_WRITE && !s.locked) begin
          next_s.scratch = word & usb_gen_regs_pkg::SCRATCH_MASK;
        end
      end
    end

    // protection engages whenever the bus is suspended and holds until the unlock key is written
    if (usbEvents.busSuspended) begin
      next_s.locked = 1'b1;
    end

    // frame number follows good start-of-frame packets only; bus reset leaves it
    if (usbEvents.frameValid) begin
      next_s.frame = usbEvents.frameNumber;
    end

    // endpoint flags clear on their own status read
    clearMask = clearMask | {usbEvents.endpointStatusRead, 8'h00};
    setMask[usb_gen_regs_pkg::INT_BUS_RESET]    = usbEvents.busReset;
    setMask[usb_gen_regs_pkg::INT_RESUME]       = usbEvents.resumeEvent;
    setMask[usb_gen_regs_pkg::INT_SUSPEND]      = usbEvents.suspendEvent;
    setMask[usb_gen_regs_pkg::INT_TRANSFER_END] = usbEvents.transferEnd;
    setMask[usb_gen_regs_pkg::INT_FRAME_START]  = usbEvents.frameValid;
    setMask[usb_gen_regs_pkg::INT_PSEUDO_FRAME] = usbEvents.pseudoFrame;
    setMask[usb_gen_regs_pkg::INT_ENDPOINT_LSB +: usb_gen_regs_pkg::ENDPOINT_COUNT] = usbEvents.endpointEvent;
    // a set in the clearing cycle wins
    next_s.flags = (s.flags & ~clearMask) | setMask;

    next_s.intRequest = |(next_s.flags & intEnable & usb_gen_regs_pkg::REQUEST_MASK);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s.sync1      <= usb_gen_regs_pkg::PINS_RESET;
      s.sync2      <= usb_gen_regs_pkg::PINS_RESET;
      s.sync3      <= usb_gen_regs_pkg::PINS_RESET;
      s.filt       <= usb_gen_regs_pkg::PINS_RESET;
      s.cmd        <= 8'h00;
      s.idx        <= 2'h0;
      s.lowHold    <= 8'h00;
      s.scratch    <= usb_gen_regs_pkg::SCRATCH_RESET;
      s.frame      <= usb_gen_regs_pkg::FRAME_RESET;
      s.flags      <= usb_gen_regs_pkg::FLAGS_RESET;
      s.snap       <= 32'h00000000;
      s.locked     <= 1'b0;
      s.dataOut    <= 16'h0000;
      s.dataOe     <= 1'b0;
      s.intRequest <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign hostDataOut = s.dataOut;
  assign hostDataOe  = s.dataOe;
  assign intRequest  = s.intRequest;
  assign writeLocked = s.locked;

endmodule : usb_gen_regs

// *** rtl/usb_gen_regs_pkg.sv ***
// constants, field positions and carrier types for the general command register set
// assumes a single 125 MHz system clock domain; nothing here holds state
package usb_gen_regs_pkg;

  // command codes, taken from the low data byte in the command phase
  localparam logic [7:0] CMD_UNLOCK        = 8'hB0;
  localparam logic [7:0] CMD_SCRATCH_WRITE = 8'hB2;
  localparam logic [7:0] CMD_SCRATCH_READ  = 8'hB3;
  localparam logic [7:0] CMD_FRAME_READ    = 8'hB4;
  localparam logic [7:0] CMD_IDENT_READ    = 8'hB5;
  localparam logic [7:0] CMD_INT_READ      = 8'hC0;

  // unlock key value, low byte first on a narrow bus
  localparam logic [15:0] UNLOCK_KEY = 16'hAA37;

  // scratch storage: bit 15 never holds a one
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam logic [15:0] SCRATCH_MASK  = 16'h7FFF;

  // frame number: 11 stored bits, upper five read zero
  localparam int unsigned FRAME_BITS  = 11;
  localparam logic [10:0] FRAME_RESET = 11'h000;

  // interrupt source layout
  localparam int unsigned INT_BUS_RESET    = 0;
  localparam int unsigned INT_RESUME       = 1;
  localparam int unsigned INT_SUSPEND      = 2;
  localparam int unsigned INT_TRANSFER_END = 3;
  localparam int unsigned INT_FRAME_START  = 4;
  localparam int unsigned INT_PSEUDO_FRAME = 5;
  localparam int unsigned INT_BUS_STATE    = 7;
  localparam int unsigned INT_ENDPOINT_LSB = 8;
  localparam int unsigned ENDPOINT_COUNT   = 16;
  localparam logic [23:0] FLAGS_RESET      = 24'h000000;
  // flags dropped when a full interrupt source read completes
  localparam logic [23:0] CLEAR_ON_READ    = 24'h00003F;
  // flags that may raise the request line
  localparam logic [23:0] REQUEST_MASK     = 24'hFFFF3F;

  // positions in the synchronised pin vector
  localparam int unsigned PIN_DATA_LSB = 0;
  localparam int unsigned PIN_CS       = 16;
  localparam int unsigned PIN_RD       = 17;
  localparam int unsigned PIN_WR       = 18;
  localparam int unsigned PIN_SEL      = 19;
  localparam int unsigned PIN_WIDE     = 20;
  localparam int unsigned PIN_COUNT    = 21;
  localparam logic [20:0] PINS_RESET   = 21'h070000;

  typedef struct packed {
    logic        busWide16;
    logic        commandDataSelect;
    logic        hostWrN;
    logic        hostRdN;
    logic        hostCsN;
    logic [15:0] hostDataIn;
  } hostPins_t;

  typedef struct packed {
    logic                      busSuspended;
    logic                      busReset;
    logic                      resumeEvent;
    logic                      suspendEvent;
    logic                      transferEnd;
    logic                      pseudoFrame;
    logic                      frameValid;
    logic [10:0]               frameNumber;
    logic [ENDPOINT_COUNT-1:0] endpointEvent;
    logic [ENDPOINT_COUNT-1:0] endpointStatusRead;
  } usbEvents_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [PIN_COUNT-1:0] sync3;
    logic [PIN_COUNT-1:0] filt;
    logic [7:0]           cmd;
    logic [1:0]           idx;
    logic [7:0]           lowHold;
    logic [15:0]          scratch;
    logic [10:0]          frame;
    logic [23:0]          flags;
    logic [31:0]          snap;
    logic                 locked;
    logic [15:0]          dataOut;
    logic                 dataOe;
    logic                 intRequest;
  } state_t;

endpackage : usb_gen_regs_pkg

// *** verification/host_port_model.sv ***
// host processor on the parallel command/data port
// assumes the bench calls the tasks just after a rising edge
`timescale 1ns/1ns
module host_port_model (
  input  wire logic                   sys_clk,
  input  wire logic [15:0]            hostDataOut,
  output usb_gen_regs_pkg::hostPins_t hostPins
);
  initial hostPins = '{hostCsN: 1'b1, hostRdN: 1'b1, hostWrN: 1'b1, default: '0};

  task automatic strobe(input logic sel, input logic isRd, input logic [15:0] d, output logic [15:0] q);
    @(posedge sys_clk);
    #1;
    hostPins.commandDataSelect = sel;
    if (!isRd) hostPins.hostDataIn = d;
    repeat (4) @(posedge sys_clk);
    #1;
    hostPins.hostCsN = 1'b0;
    hostPins.hostRdN = !isRd;
    hostPins.hostWrN = isRd;
    repeat (5) @(posedge sys_clk);
    #1;
    q = hostDataOut;
    hostPins.hostCsN = 1'b1;
    hostPins.hostRdN = 1'b1;
    hostPins.hostWrN = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    // released lines show the inverse of the last value
    hostPins.hostDataIn = ~hostPins.hostDataIn;
  endtask : strobe

  task automatic write_reg(input logic [7:0] code, input logic [15:0] w, input logic wide);
    logic [15:0] q;
    hostPins.busWide16 = wide;
    strobe(1'b1, 1'b0, {~code, code}, q);
    if (wide) strobe(1'b0, 1'b0, w, q);
    else begin
      strobe(1'b0, 1'b0, {8'h00, w[7:0]}, q);
      strobe(1'b0, 1'b0, {8'h00, w[15:8]}, q);
    end
  endtask : write_reg

  task automatic read_reg(input logic [7:0] code, input int n, input logic wide, output logic [31:0] v);
    logic [15:0] q;
    v = '0;
    hostPins.busWide16 = wide;
    strobe(1'b1, 1'b0, {~code, code}, q);
    for (int i = 0; i < n; i++) begin
      strobe(1'b0, 1'b1, 16'h0000, q);
      if (wide) v[i*16 +: 16] = q;
      else v[i*8 +: 8] = q[7:0];
    end
  endtask : read_reg
endmodule : host_port_model

// *** verification/tb_top.sv ***
// self-checking bench for the general command register set
// assumes host_port_model drives the port; usb events come from here
`timescale 1ns/1ns
module tb_top;
  logic                         sys_clk = 1'b0;
  logic                         arst_n;
  usb_gen_regs_pkg::hostPins_t  hostPins;
  usb_gen_regs_pkg::usbEvents_t ev;
  usb_gen_regs_pkg::usbEvents_t e;
  logic [23:0]                  intEnable;
  logic [23:0]                  flags = 24'h000000;
  logic [15:0]                  hostDataOut;
  logic                         hostDataOe;
  logic                         intRequest;
  logic                         writeLocked;
  logic [31:0]                  seed = 32'h861A81D4;
  logic [31:0]                  r;
  logic [31:0]                  v;
  logic [15:0]                  scratch;
  logic [10:0]                  frame = 11'h000;
  int                           mismatches = 0;
  int                           compares = 0;
  localparam logic [15:0]       IDENT = 16'h3C27; // arbitrary value

  always #4 sys_clk = ~sys_clk;

  usb_gen_regs #(.IDENT_CODE(IDENT[15:8]), .SILICON_VERSION(IDENT[7:0])) i_usb_gen_regs (
    .sys_clk(sys_clk), .arst_n(arst_n), .hostPins(hostPins), .usbEvents(ev), .intEnable(intEnable),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .intRequest(intRequest), .writeLocked(writeLocked));
  host_port_model h (.sys_clk(sys_clk), .hostDataOut(hostDataOut), .hostPins(hostPins));

  function automatic logic [31:0] nxt();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction : nxt

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    compares++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic pulse(input usb_gen_regs_pkg::usbEvents_t p);
    @(posedge sys_clk);
    #1;
    ev = p;
    @(posedge sys_clk);
    #1;
    ev = '{frameNumber: ~p.frameNumber, default: '0};
  endtask : pulse

  task automatic stop_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  initial begin
    #200000;
    mismatches++;
    stop_test();
  end

  initial begin
    arst_n = 1'b0;
    intEnable = 24'h000000;
    ev = '0;
    repeat (20) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    chk("locked", 0, writeLocked);
    h.read_reg(8'hB3, 2, 1'b0, v);
    chk("scratch", 0, v);
    h.read_reg(8'hC0, 4, 1'b0, v);
    chk("int", 0, v);
    for (int k = 0; k < 4; k++) begin
      r = nxt() | (k == 0 ? 32'h8000003F : 32'h0);
      e = '{busReset: r[0], resumeEvent: r[1], suspendEvent: r[2], transferEnd: r[3], frameValid: r[4],
            pseudoFrame: r[5], frameNumber: r[26:16], endpointEvent: r[31:16], default: '0};
      flags |= {r[31:16], 2'b00, r[5:0]};
      if (r[4]) frame = r[26:16];
      v = nxt();
      intEnable = v[23:0] | 24'h800001;
      pulse(e);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("request", |(flags & intEnable & 24'hFFFF3F), intRequest);
      h.read_reg(8'hB4, 2 - k[0], k[0], v);
      chk("frame", frame, v);
      h.read_reg(8'hB4, 1, 1'b0, v);
      chk("frame low", frame[7:0], v);
      v = nxt();
      scratch = v[15:0] & 16'h7FFF;
      h.write_reg(8'hB2, scratch, k[0]);
      h.read_reg(8'hB3, 1 + k[0], !k[0], v);
      chk("scratch", scratch, v);
      h.read_reg(8'hB5, 2 - k[0], k[0], v);
      chk("ident", IDENT, v);
      h.read_reg(8'hC0, 4 - 2 * k[0], k[0], v);
      chk("int", {8'h00, flags[23:8], 2'b00, flags[5:0]}, v);
      flags &= 24'hFFFFC0;
    end
    intEnable = 24'h0000C0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("masked", 0, intRequest);
    pulse('{endpointStatusRead: 16'hFFFF, default: '0});
    flags = 24'h000000;
    h.read_reg(8'hC0, 2, 1'b1, v);
    chk("int", 0, v);
    ev.busSuspended = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    ev.busSuspended = 1'b0;
    chk("locked", 1, writeLocked);
    h.write_reg(8'hB2, 16'h1234, 1'b0);
    pulse('{transferEnd: 1'b1, default: '0});
    h.read_reg(8'hC0, 4, 1'b0, v);
    chk("locked int", 0, v);
    h.write_reg(8'hB0, 16'hAA36, 1'b0);
    chk("locked", 1, writeLocked);
    h.write_reg(8'hB0, 16'hAA37, 1'b0);
    chk("locked", 0, writeLocked);
    h.read_reg(8'hB3, 2, 1'b0, v);
    chk("scratch", scratch, v);
    h.read_reg(8'hC0, 4, 1'b0, v);
    chk("int", 32'h00000008, v);
    // a second reset in mid-run must bring back the power-up values
    arst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    chk("locked", 0, writeLocked);
    h.read_reg(8'hB3, 2, 1'b0, v);
    chk("scratch", 0, v);
    h.read_reg(8'hB4, 2, 1'b0, v);
    chk("frame", 0, v);
    stop_test();
  end
endmodule : tb_top

// *** verification/usb_gen_regs_chk.sv ***
// assertions on the ports of the general command register set
// assumes synchronous event inputs and a host keeping strobes 4+ cycles
`timescale 1ns/1ns
module usb_gen_regs_chk (
  input wire logic                         sys_clk,
  input wire logic                         arst_n,
  input wire usb_gen_regs_pkg::hostPins_t  hostPins,
  input wire usb_gen_regs_pkg::usbEvents_t usbEvents,
  input wire logic [23:0]                  intEnable,
  input wire logic [15:0]                  hostDataOut,
  input wire logic                         hostDataOe,
  input wire logic                         intRequest,
  input wire logic                         writeLocked
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_lock_suspend: assert property (usbEvents.busSuspended |-> ##[1:2] writeLocked)
    else $error("lock not set in suspend");
  a_lock_holds: assert property (writeLocked && hostPins.hostWrN |=> writeLocked)
    else $error("lock dropped without write");
  a_narrow_upper: assert property (hostDataOe && !hostPins.busWide16 && !$past(hostPins.busWide16, 4)
    |-> hostDataOut[15:8] == 8'h00)
    else $error("upper byte driven on narrow bus");
  a_oe_cause: assert property ($rose(hostDataOe) |-> !$past(hostPins.hostRdN, 2) && !$past(hostPins.hostCsN, 2)
    && !$past(hostPins.commandDataSelect, 2))
    else $error("drive without data read");
  a_oe_width: assert property ($rose(hostDataOe) |-> hostDataOe[*4])
    else $error("read data dropped early");
  a_oe_release: assert property ($rose(hostPins.hostRdN) |-> ##[2:5] !hostDataOe)
    else $error("drive kept after read");
  a_out_stable: assert property (hostDataOe && $past(hostDataOe) |-> $stable(hostDataOut))
    else $error("read data moved during read");
  a_req_masked: assert property ((((intEnable & 24'hFFFF3F) == 24'h000000))[*3] |-> !intRequest)
    else $error("request with all sources off");
  a_reset_req: assert property (usbEvents.busReset && intEnable[0] ##1 intEnable[0] |-> ##[0:1] intRequest)
    else $error("bus reset gave no request");
  a_endpoint_req: assert property (usbEvents.endpointEvent[15] && intEnable[23] ##1 intEnable[23]
    |-> ##[0:1] intRequest)
    else $error("endpoint event gave no request");
  c_read: cover property ($rose(hostDataOe));
  c_unlock: cover property ($fell(writeLocked));
  c_request: cover property ($rose(intRequest));
endmodule : usb_gen_regs_chk

bind usb_gen_regs usb_gen_regs_chk i_usb_gen_regs_chk (.sys_clk(sys_clk), .arst_n(arst_n), .hostPins(hostPins),
  .usbEvents(usbEvents), .intEnable(intEnable), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
  .intRequest(intRequest), .writeLocked(writeLocked));
